/* hdl/adcc_pkg.sv */
// package: register map, field layout and state record of the converter control block
package adcc_pkg;

  localparam int unsigned ADDR_W = 8;

  // word offsets (byte addresses)
  localparam logic [7:0] OFF_RESULT_LOW  = 8'h00;
  localparam logic [7:0] OFF_RESULT_HIGH = 8'h04;
  localparam logic [7:0] OFF_CTRL_MAIN   = 8'h08;
  localparam logic [7:0] OFF_SRC_CLOCK   = 8'h0C;
  localparam logic [7:0] OFF_REF_CTRL    = 8'h10;
  localparam logic [7:0] OFF_BANDGAP     = 8'h14;
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'h18;
  localparam logic [7:0] OFF_IRQ_CLEAR   = 8'h1C;
  localparam logic [7:0] OFF_IRQ_ENABLE  = 8'h20;

  // converter_control_main fields
  localparam int unsigned POS_START   = 7;
  localparam int unsigned POS_BUSY    = 6;
  localparam int unsigned POS_ENABLE  = 5;
  localparam int unsigned POS_JUSTIFY = 4;
  // converter_source_clock fields
  localparam int unsigned POS_SRC     = 4;
  localparam int unsigned POS_CLKDIV  = 0;
  // converter_reference_ctrl fields
  localparam int unsigned POS_AMP_EN  = 7;
  localparam int unsigned POS_AMP_IN  = 4;
  localparam int unsigned POS_REF_SRC = 2;
  localparam int unsigned POS_GAIN    = 0;
  // interrupt bits
  localparam int unsigned IRQ_DONE    = 0;
  localparam int unsigned IRQ_IGNORED = 1;
  localparam int unsigned IRQ_W       = 2;

  localparam logic [7:0] CTRL_MAIN_RESET = 8'h00;
  localparam logic [3:0] SRC_EXTERNAL    = 4'h0;
  localparam int unsigned DIV_CNT_W      = 7;

  typedef struct packed {
    logic              start_bit;
    logic              busy;
    logic              enable;
    logic              justify;
    logic [3:0]        ext_ch;
    logic [3:0]        src;
    logic [2:0]        clkdiv;
    logic              amp_en;
    logic              amp_in;
    logic [1:0]        ref_src;
    logic [1:0]        gain;
    logic              bg_en;
    logic [11:0]       result;
    logic [IRQ_W-1:0]  irq_stat;
    logic [IRQ_W-1:0]  irq_en;
    logic              irq;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              conv_start;
    logic [15:0]       ch_onehot;
    logic              ext_connect;
    logic              gnd_connect;
    logic [15:0]       pin_analog;
  } adcc_state_type;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } adcc_apb_req_type;

endpackage

/* hdl/adcc_clkdiv.sv */
// conversion clock divider: one tick every 2^sel system clocks
`timescale 1ns/1ps
module adcc_clkdiv
  import adcc_pkg::*;
#(
  parameter int unsigned SEL_W = 3
) (
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic             run,
  input  wire logic [SEL_W-1:0] sel,
  output logic                  tick
);

  typedef struct packed {
    logic [DIV_CNT_W-1:0] count;
    logic                 tick;
  } adcc_div_type;

  adcc_div_type st;
  adcc_div_type next_st;
  logic [DIV_CNT_W-1:0] last;

  if (SEL_W > 3) begin : g_chk
    $error("adcc_clkdiv: divider select wider than counter");
  end

  always_comb begin
    last = DIV_CNT_W'((1 << sel) - 1);
    next_st = st;
    next_st.tick = 1'b0;
    if (!run) begin
      next_st.count = '0;
    end else if (st.count >= last) begin // see R14
      next_st.count = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.count = st.count + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

endmodule

/* hdl/adcc_top.sv */
// converter control block: APB registers, start/busy sequencing, result formatting, input routing
// Operation
// R1: a conversion starts only when start is written high then low again
// R2: busy rises when a conversion starts and falls when it completes
// R3: enable bit powers the converter; low switches it off
// R4: while disabled both result bytes keep their old contents
// R5: justify 0: high byte D11..D4, low byte D3..D0 in upper nibble, lower nibble zero
// R6: justify 1: high byte D11..D8 in lower nibble, low byte D7..D0
// R7: result bits unused by the chosen format read zero
// R8: every result is a 12-bit unsigned value for any source
// R9: channel codes 0..11 route input n; 12..15 connect nothing
// R10: an internal source disconnects the external channel regardless of channel code
// R11: a pin used as converter input loses its digital function and pull-up
// R12: bandgap register bit 0 enables the reference; other bits unimplemented
// R13: main control resets to zero; busy read-only, others read/write
// R14: clock select codes 0..7 divide system clock by 1..128
// R15: source code 0 external, 1..3 supply fractions, 10xx ground
// R16: start pulse while busy is ignored; running conversion completes
`timescale 1ns/1ps
module adcc_top
  import adcc_pkg::*;
#(
  parameter int unsigned NUM_CH = 12,
  parameter int unsigned RES_W  = 12
) (
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              core_done,
  input  wire logic [RES_W-1:0]  core_result,
  input  wire logic [NUM_CH-1:0] pin_analog_sel,
  output logic                   conv_start,
  output logic                   conv_clk_tick,
  output logic                   converter_enable,
  output logic [NUM_CH-1:0]      analog_input_n_connect,
  output logic                   ext_input_connect,
  output logic                   ground_input_connect,
  output logic [3:0]             input_source_sel,
  output logic                   ref_amplifier_enable,
  output logic                   amplifier_input_sel,
  output logic [1:0]             reference_source_sel,
  output logic [1:0]             amplifier_gain_sel,
  output logic                   bandgap_enable,
  output logic [NUM_CH-1:0]      pin_function_override,
  output logic                   irq
);

  if (NUM_CH > 15 || NUM_CH == 0 || RES_W != 12) begin : g_chk
    $error("adcc_top: channel count or result width unsupported");
  end

  adcc_state_type st;
  adcc_state_type next_st;
  adcc_apb_req_type req;

  logic access;
  logic wr_now;
  logic start_fall;
  logic trigger;
  logic done_evt;
  logic src_internal;
  logic [IRQ_W-1:0] evt;
  logic [IRQ_W-1:0] clr;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  function automatic logic [7:0] fmt_low(input logic [11:0] r, input logic j);
    fmt_low = j ? r[7:0] : {r[3:0], 4'h0}; // see R5 // see R6
  endfunction

  function automatic logic [7:0] fmt_high(input logic [11:0] r, input logic j);
    fmt_high = j ? {4'h0, r[11:8]} : r[11:4]; // see R5 // see R6
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == OFF_RESULT_LOW) || (a == OFF_RESULT_HIGH) || (a == OFF_CTRL_MAIN) ||
                (a == OFF_SRC_CLOCK) || (a == OFF_REF_CTRL) || (a == OFF_BANDGAP) ||
                (a == OFF_IRQ_STATUS) || (a == OFF_IRQ_CLEAR) || (a == OFF_IRQ_ENABLE);
  endfunction

  adcc_clkdiv #(
    .SEL_W (3)
  ) u_div (
    .mclk    (mclk),
    .reset_n (reset_n),
    .run     (st.enable),
    .sel     (st.clkdiv),
    .tick    (conv_clk_tick)
  );

  always_comb begin
    next_st = st;
    // first access cycle computes the answer, second (pready high) commits
    access = req.psel && req.penable && !st.pready;
    wr_now = req.psel && req.penable && st.pready && req.pwrite && !st.pslverr;
    start_fall = wr_now && (req.paddr == OFF_CTRL_MAIN) && st.start_bit && !req.pwdata[POS_START]; // see R1
    trigger = start_fall && st.enable && !st.busy; // see R1 // see R16
    done_evt = st.busy && core_done;
    evt = '0;
    clr = '0;
    evt[IRQ_DONE] = done_evt;
    evt[IRQ_IGNORED] = start_fall && st.busy; // see R16
    // internal source codes 0001..0011, 0101..0111 and ground 10xx
    src_internal = !((st.src == SRC_EXTERNAL) || (st.src == 4'h4) || (st.src[3:2] == 2'b11)); // see R15

    next_st.pready = access;
    next_st.pslverr = access && !is_mapped(req.paddr);
    next_st.conv_start = trigger;
    if (access) begin
      next_st.prdata = '0;
      unique case (req.paddr)
        OFF_RESULT_LOW:  next_st.prdata[7:0] = fmt_low(st.result, st.justify); // see R7
        OFF_RESULT_HIGH: next_st.prdata[7:0] = fmt_high(st.result, st.justify); // see R7
        OFF_CTRL_MAIN:   next_st.prdata[7:0] = {st.start_bit, st.busy, st.enable, st.justify, st.ext_ch};
        OFF_SRC_CLOCK:   next_st.prdata[7:0] = {st.src, 1'b0, st.clkdiv};
        OFF_REF_CTRL:    next_st.prdata[7:0] = {st.amp_en, 2'b00, st.amp_in, st.ref_src, st.gain};
        OFF_BANDGAP:     next_st.prdata[7:0] = {7'h00, st.bg_en}; // see R12
        OFF_IRQ_STATUS:  next_st.prdata[IRQ_W-1:0] = st.irq_stat;
        OFF_IRQ_ENABLE:  next_st.prdata[IRQ_W-1:0] = st.irq_en;
        default:         next_st.prdata = '0;
      endcase
    end

    if (wr_now) begin
      unique case (req.paddr)
        OFF_CTRL_MAIN: begin
          // busy is not writable
          next_st.start_bit = req.pwdata[POS_START]; // see R13
          next_st.enable    = req.pwdata[POS_ENABLE]; // see R3
          next_st.justify   = req.pwdata[POS_JUSTIFY];
          next_st.ext_ch    = req.pwdata[3:0];
        end
        OFF_SRC_CLOCK: begin
          next_st.src    = req.pwdata[POS_SRC +: 4];
          next_st.clkdiv = req.pwdata[POS_CLKDIV +: 3]; // see R14
        end
        OFF_REF_CTRL: begin
          next_st.amp_en  = req.pwdata[POS_AMP_EN];
          next_st.amp_in  = req.pwdata[POS_AMP_IN];
          next_st.ref_src = req.pwdata[POS_REF_SRC +: 2];
          next_st.gain    = req.pwdata[POS_GAIN +: 2];
        end
        OFF_BANDGAP:    next_st.bg_en = req.pwdata[0]; // see R12
        OFF_IRQ_CLEAR:  clr = req.pwdata[IRQ_W-1:0];
        OFF_IRQ_ENABLE: next_st.irq_en = req.pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end

    // busy: set by a valid start, cleared by completion or by power-off
    if (trigger) begin
      next_st.busy = 1'b1; // see R2
    end else if (done_evt || !st.enable) begin
      next_st.busy = 1'b0; // see R2
    end
    // a disabled converter never overwrites the result pair
    if (done_evt && st.enable) begin
      next_st.result = core_result; // see R4 // see R8
    end

    // set wins over a clear in the same cycle
    next_st.irq_stat = (st.irq_stat & ~clr) | evt;
    next_st.irq = |(next_st.irq_stat & next_st.irq_en);

    // channel routing from the currently held fields
    next_st.ch_onehot = '0;
    if (!src_internal && (st.ext_ch < 4'(NUM_CH))) begin
      next_st.ch_onehot[st.ext_ch] = 1'b1; // see R9 // see R10
    end
    next_st.ext_connect = !src_internal && (st.ext_ch < 4'(NUM_CH)); // see R10
    next_st.gnd_connect = (st.src[3:2] == 2'b10); // see R15
    next_st.pin_analog = 16'(pin_analog_sel); // see R11
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0; // see R13
    end else begin
      st <= next_st;
    end
  end

  assign prdata                 = st.prdata;
  assign pready                 = st.pready;
  assign pslverr                = st.pslverr;
  assign conv_start             = st.conv_start;
  assign converter_enable       = st.enable; // see R3
  assign analog_input_n_connect = st.ch_onehot[NUM_CH-1:0];
  assign ext_input_connect      = st.ext_connect;
  assign ground_input_connect   = st.gnd_connect;
  assign input_source_sel       = st.src;
  assign ref_amplifier_enable   = st.amp_en;
  assign amplifier_input_sel    = st.amp_in;
  assign reference_source_sel   = st.ref_src;
  assign amplifier_gain_sel     = st.gain;
  assign bandgap_enable         = st.bg_en;
  assign pin_function_override  = st.pin_analog[NUM_CH-1:0];
  assign irq                    = st.irq;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  sequence s_valid_start;
    $fell(st.start_bit) && $past(st.enable) && !$past(st.busy);
  endsequence

  sequence s_busy_then_done;
    st.busy && core_done;
  endsequence

  property p_start_needs_fall;
    $rose(st.busy) |-> $fell(st.start_bit) ##0 $rose(conv_start);
  endproperty
  a_start_needs_fall: assert property (p_start_needs_fall) else $error("busy rose without start fall"); // see R1

  property p_busy_on_start;
    s_valid_start |-> st.busy && conv_start;
  endproperty
  a_busy_on_start: assert property (p_busy_on_start) else $error("valid start did not set busy"); // see R2

  property p_busy_clears;
    s_busy_then_done |=> !st.busy ##1 !st.busy || conv_start;
  endproperty
  a_busy_clears: assert property (p_busy_clears) else $error("busy stayed after completion"); // see R2

  property p_off_clears_busy;
    !st.enable |=> !st.busy;
  endproperty
  a_off_clears_busy: assert property (p_off_clears_busy) else $error("busy while converter off"); // see R3

  property p_hold_disabled;
    !st.enable |=> $stable(st.result);
  endproperty
  a_hold_disabled: assert property (p_hold_disabled) else $error("result changed while disabled"); // see R4

  property p_fmt_left;
    access && !req.pwrite && req.paddr == OFF_RESULT_LOW && !st.justify |=>
      prdata[7:0] == {$past(st.result[3:0]), 4'h0};
  endproperty
  a_fmt_left: assert property (p_fmt_left) else $error("left format low byte wrong"); // see R5

  property p_fmt_right;
    access && !req.pwrite && req.paddr == OFF_RESULT_HIGH && st.justify |=>
      prdata[7:0] == {4'h0, $past(st.result[11:8])};
  endproperty
  a_fmt_right: assert property (p_fmt_right) else $error("right format high byte wrong"); // see R6

  property p_upper_zero;
    access && (req.paddr == OFF_RESULT_LOW || req.paddr == OFF_RESULT_HIGH) |=> prdata[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("unused result bits not zero"); // see R7

  property p_result_capture;
    s_busy_then_done ##0 st.enable |=> st.result == $past(core_result);
  endproperty
  a_result_capture: assert property (p_result_capture) else $error("result not captured"); // see R8

  property p_no_channel_high_code;
    st.ext_ch >= 4'(NUM_CH) |=> analog_input_n_connect == '0 && !ext_input_connect;
  endproperty
  a_no_channel_high_code: assert property (p_no_channel_high_code) else $error("floating code connected"); // see R9

  property p_internal_isolates;
    src_internal |=> analog_input_n_connect == '0;
  endproperty
  a_internal_isolates: assert property (p_internal_isolates) else $error("external input left connected"); // see R10

  // completion or power-off in the same cycle ends the conversion anyway
  property p_ignored_start;
    st.busy && st.enable && !core_done && start_fall |=> st.busy && !conv_start && st.irq_stat[IRQ_IGNORED];
  endproperty
  a_ignored_start: assert property (p_ignored_start) else $error("start while busy not ignored"); // see R16

  property p_pready_single;
    pready |=> !pready;
  endproperty
  a_pready_single: assert property (p_pready_single) else $error("pready held longer than one cycle");

  property p_pready_answer;
    access |=> pready;
  endproperty
  a_pready_answer: assert property (p_pready_answer) else $error("access not answered after one wait");

  property p_slverr_qualified;
    pslverr |-> pready && prdata == 32'h00000000;
  endproperty
  a_slverr_qualified: assert property (p_slverr_qualified) else $error("error response malformed");

  property p_busy_source;
    $rose(st.busy) |-> $past(trigger);
  endproperty
  a_busy_source: assert property (p_busy_source) else $error("busy set without valid start"); // see R13

  property p_start_single;
    conv_start |=> !conv_start;
  endproperty
  a_start_single: assert property (p_start_single) else $error("start pulse longer than one cycle"); // see R1

  property p_no_start_off;
    !st.enable |=> !conv_start;
  endproperty
  a_no_start_off: assert property (p_no_start_off) else $error("start while converter off"); // see R3

  property p_result_only_on_done;
    !(st.busy && core_done) |=> $stable(st.result);
  endproperty
  a_result_only_on_done: assert property (p_result_only_on_done) else $error("result changed without done"); // see R4

  property p_done_status;
    s_busy_then_done |=> st.irq_stat[IRQ_DONE] && !st.busy;
  endproperty
  a_done_status: assert property (p_done_status) else $error("completion not flagged"); // see R2

  property p_irq_level;
    irq == |(st.irq_stat & st.irq_en);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level does not match status");

  property p_ground_code;
    st.src[3:2] == 2'b10 |=> ground_input_connect;
  endproperty
  a_ground_code: assert property (p_ground_code) else $error("ground code not grounded"); // see R15

  property p_bandgap_read;
    access && !req.pwrite && req.paddr == OFF_BANDGAP |=> prdata == {31'h00000000, $past(st.bg_en)};
  endproperty
  a_bandgap_read: assert property (p_bandgap_read) else $error("bandgap read wrong"); // see R12

  property p_channel_route;
    !src_internal && st.ext_ch < 4'(NUM_CH) |=>
      $onehot(analog_input_n_connect) && analog_input_n_connect[$past(st.ext_ch)];
  endproperty
  a_channel_route: assert property (p_channel_route) else $error("selected channel not routed"); // see R9

  property p_override_follows;
    1'b1 |=> pin_function_override == $past(pin_analog_sel);
  endproperty
  a_override_follows: assert property (p_override_follows) else $error("pin override lags"); // see R11

endmodule

/* test/adcc_core_model.sv */
// partner model: analog mux and successive-approximation core behind the control block
`timescale 1ns/1ps
module adcc_core_model (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        conv_start,
  input  wire logic        converter_enable,
  input  wire logic [7:0]  delay,
  input  wire logic [11:0] value,
  output logic             core_done,
  output logic [11:0]      core_result
);
  int cnt;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt         <= 0;
      core_done   <= 1'b0;
      core_result <= 12'hA5A;
    end else begin
      core_done <= 1'b0;
      // result bus is not held outside the done cycle
      core_result <= ~core_result;
      if (!converter_enable)
        cnt <= 0;
      else if (conv_start)
        cnt <= int'(delay) + 1;
      else if (cnt > 1)
        cnt <= cnt - 1;
      else if (cnt == 1) begin
        cnt         <= 0;
        core_done   <= 1'b1;
        core_result <= value;
      end
    end
  end
endmodule

/* test/tb_top.sv */
// self-checking bench of the converter control block
`timescale 1ns/1ps
module tb_top;
  import adcc_pkg::*;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        core_done;
  logic [11:0] core_result;
  logic [11:0] pin_analog_sel = 12'h000;
  logic        conv_start;
  logic        tick;
  logic        conv_en;
  logic [11:0] conn;
  logic        ext_c;
  logic        gnd_c;
  logic [3:0]  src_sel;
  logic        amp_en;
  logic        amp_in;
  logic [1:0]  ref_src;
  logic [1:0]  gain;
  logic        bg_en;
  logic [11:0] override;
  logic        irq;
  logic [7:0]  delay = 8'h10;
  logic [11:0] value = 12'h000;
  logic [31:0] seed = 32'hC329;
  logic [31:0] rd;
  logic [11:0] prev;
  logic [3:0]  s4;
  logic        ext;
  logic        err;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          starts = 0;
  int          exp_starts = 0;
  int          res = 0;
  int          n;

  initial forever #2 mclk = ~mclk;

  adcc_top i_adcc_top (
    .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_done(core_done),
    .core_result(core_result), .pin_analog_sel(pin_analog_sel), .conv_start(conv_start),
    .conv_clk_tick(tick), .converter_enable(conv_en), .analog_input_n_connect(conn),
    .ext_input_connect(ext_c), .ground_input_connect(gnd_c), .input_source_sel(src_sel),
    .ref_amplifier_enable(amp_en), .amplifier_input_sel(amp_in), .reference_source_sel(ref_src),
    .amplifier_gain_sel(gain), .bandgap_enable(bg_en), .pin_function_override(override), .irq(irq)
  );

  adcc_core_model i_adcc_core_model (
    .mclk(mclk), .reset_n(reset_n), .conv_start(conv_start), .converter_enable(conv_en),
    .delay(delay), .value(value), .core_done(core_done), .core_result(core_result)
  );

  always @(posedge mclk) if (conv_start === 1'b1) starts++;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] ctl(input logic st, input logic en, input logic j, input logic [3:0] ch);
    return {24'h0, st, 1'b0, en, j, ch};
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd  = prdata;
    err = pslverr;
    check("apb_wait", k < 50, 1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask

  task automatic chkres(input logic j, input logic en);
    wr(OFF_CTRL_MAIN, ctl(0, en, j, 0));
    rc("result_high", OFF_RESULT_HIGH, j ? res >> 8 : (res >> 4) & 255);
    rc("result_low", OFF_RESULT_LOW, j ? res & 255 : (res & 15) << 4);
  endtask

  // start pulse, optionally a second pulse while busy, then wait for completion
  task automatic conv(input logic j, input logic ign);
    logic [31:0] r;
    int          k;
    r = rnd();
    value <= r[11:0];
    delay <= {3'b0, r[20:16]} + 8'd20;
    wr(OFF_CTRL_MAIN, ctl(1, 1, j, 0));
    rc("no_start_on_set", OFF_CTRL_MAIN, ctl(1, 1, j, 0));
    wr(OFF_CTRL_MAIN, ctl(0, 1, j, 0));
    exp_starts++;
    rc("busy_high", OFF_CTRL_MAIN, ctl(0, 1, j, 0) | 32'h40);
    if (ign) begin
      wr(OFF_CTRL_MAIN, ctl(1, 1, j, 0));
      wr(OFF_CTRL_MAIN, ctl(0, 1, j, 0));
    end
    k = 0;
    while (core_done !== 1'b1 && k < 200) begin
      @(posedge mclk);
      k++;
    end
    check("done_wait", k < 200, 1);
    res = int'(r[11:0]);
    repeat (3) @(posedge mclk);
    check("start_count", starts, exp_starts);
    rc("busy_low", OFF_CTRL_MAIN, ctl(0, 1, j, 0));
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    rc("ctrl_reset", OFF_CTRL_MAIN, 32'h0);
    wr(OFF_CTRL_MAIN, 32'h7F);
    rc("busy_readonly", OFF_CTRL_MAIN, 32'h3F);
    check("enable_out", conv_en, 1);
    wr(OFF_CTRL_MAIN, 32'h00);
    apb(1'b0, 8'h24, 32'h0);
    check("unmapped_err", {rd[30:0], err}, 1);
    wr(OFF_REF_CTRL, 32'hFF);
    rc("ref_ctrl", OFF_REF_CTRL, 32'h9F);
    check("ref_outputs", {amp_en, amp_in, ref_src, gain}, 6'h3F);
    wr(OFF_BANDGAP, 32'hFF);
    rc("bandgap", OFF_BANDGAP, 32'h01);
    check("bandgap_out", bg_en, 1);
    for (int i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (i > 1)
        check("pin_override", override, prev);
      prev = pin_analog_sel;
      pin_analog_sel <= 12'(rnd());
    end
    for (int i = 0; i < 16; i++) begin
      s4  = 4'((i * 5) % 16);
      ext = (s4 == 0) || (s4 == 4) || (s4[3:2] == 2'b11);
      wr(OFF_SRC_CLOCK, {s4, 4'hF});
      rc("src_clock", OFF_SRC_CLOCK, {s4, 4'h7});
      wr(OFF_CTRL_MAIN, ctl(0, 1, 0, 4'(i)));
      repeat (2) @(posedge mclk);
      check("channel", conn, (ext && i < 12) ? 12'(1 << i) : 12'h0);
      check("ext_path", ext_c, ext && i < 12);
      check("ground", gnd_c, s4[3:2] == 2'b10);
      check("source", src_sel, s4);
    end
    for (int s = 0; s < 8; s++) begin
      wr(OFF_SRC_CLOCK, s);
      for (int t = 0; t < 3; t++) begin
        n = 0;
        do begin
          @(posedge mclk);
          n++;
        end while (tick !== 1'b1 && n < 300);
      end
      check("tick_gap", n, 1 << s);
    end
    wr(OFF_SRC_CLOCK, 32'h0);
    wr(OFF_IRQ_ENABLE, 32'h3);
    rc("irq_enable", OFF_IRQ_ENABLE, 32'h3);
    for (int k = 0; k < 4; k++) begin
      conv(k[0], k == 3);
      rc("irq_status", OFF_IRQ_STATUS, k == 3 ? 3 : 1);
      check("irq_set", irq, 1);
      chkres(0, 1);
      chkres(1, 1);
      wr(OFF_IRQ_CLEAR, 32'h3);
      repeat (2) @(posedge mclk);
      check("irq_clear", irq, 0);
    end
    wr(OFF_IRQ_ENABLE, 32'h0);
    conv(1, 0);
    check("irq_masked", irq, 0);
    rc("status_masked", OFF_IRQ_STATUS, 32'h1);
    wr(OFF_IRQ_ENABLE, 32'h1);
    repeat (2) @(posedge mclk);
    check("irq_unmasked", irq, 1);
    wr(OFF_IRQ_CLEAR, 32'h1);
    wr(OFF_CTRL_MAIN, ctl(1, 0, 0, 0));
    wr(OFF_CTRL_MAIN, ctl(0, 0, 0, 0));
    repeat (60) @(posedge mclk);
    check("start_disabled", starts, exp_starts);
    check("enable_off", {conv_en, tick}, 0);
    chkres(0, 0);
    chkres(1, 0);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    summarize();
  end
endmodule
